// file: kip_regs.svh
`ifndef KIP_REGS_SVH
`define KIP_REGS_SVH
// Contract
// - each of four input pins has a pull-down, chosen per bit at build time
// - every input bit can raise the interrupt, each bit enabled or masked by software
// - an enabled bit going active sets the shared interrupt flag to 1
// - with enables unchanged, only a low-to-high edge sets the flag, not a level
// - enabling a bit while its pin is high may set the flag again
// - optional noise rejection delays flag setting by at most 0.5 ms
// - word 0E0H reads the four pin levels; writes do nothing
// - word 0E8H holds read/write enables, 1 enables, all zero after reset
// - flag sits in D0 of word 0EDH; upper three bits read zero
// - flag clears when read, ignores writes, zero after reset

// ****************************************
// register map
// ****************************************
`define KIP_ADDR_PIN_LEVELS   8'hE0
`define KIP_ADDR_IRQ_ENABLES  8'hE8
`define KIP_ADDR_IRQ_FLAG     8'hED
`define KIP_RST_IRQ_ENABLES   4'h0
`define KIP_RST_IRQ_FLAG      1'h0
`define KIP_FLAG_BIT          0
`define KIP_RDATA_IDLE        4'h0

// ****************************************
// build options and timing
// ****************************************
`define KIP_PULLDOWN_OPT      4'hF
`define KIP_NOISE_REJECT_OPT  1'h1
`define KIP_CLK_FREQ_KHZ      50000
`define KIP_REJECT_TIME_US    500
`define KIP_REJECT_CYCLES     ((`KIP_REJECT_TIME_US * `KIP_CLK_FREQ_KHZ) / 1000)
`endif

// file: kip_pkg.sv
package kip_pkg;
	typedef logic [3:0] kip_nib_t;
	typedef enum logic [1:0] {
		KIP_SEL_NONE,
		KIP_SEL_PINS,
		KIP_SEL_EN,
		KIP_SEL_FLAG
	} kip_sel_t;
endpackage

// file: kip_filt_if.sv
interface kip_filt_if;
	import kip_pkg::*;
	kip_nib_t raw;
	kip_nib_t clean;
	modport src (output raw, input clean);
	modport flt (input raw, output clean);
endinterface

// file: kip_filter.sv
`include "kip_regs.svh"
module kip_filter import kip_pkg::*; #(
	parameter bit          USE_FILTER    = `KIP_NOISE_REJECT_OPT,
	parameter int unsigned REJECT_CYCLES = `KIP_REJECT_CYCLES
) (
	input  wire logic core_clk,
	input  wire logic resetn,
	kip_filt_if.flt   f
);
	// ****************************************
	// per-bit stability counters
	// ****************************************
	localparam logic [15:0] LAST = 16'(REJECT_CYCLES - 1);

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_bit
			logic [15:0] cnt_q;
			logic        clean_q;
			always_ff @(posedge core_clk or negedge resetn) begin
				if (!resetn) begin
					cnt_q   <= 16'h0000;
					clean_q <= 1'b0;
				end else if (!USE_FILTER || REJECT_CYCLES < 2) begin
					cnt_q   <= 16'h0000;
					clean_q <= f.raw[gi];
				end else if (f.raw[gi] == clean_q) begin
					cnt_q <= 16'h0000; // a glitch restarts the wait
				end else if (cnt_q == LAST) begin
					cnt_q   <= 16'h0000;
					clean_q <= f.raw[gi];
				end else begin
					cnt_q <= cnt_q + 16'h0001;
				end
			end
			assign f.clean[gi] = clean_q;
		end
	endgenerate
endmodule

// file: kip_top.sv
`include "kip_regs.svh"
module kip_top import kip_pkg::*; #(
	parameter int unsigned REJECT_CYCLES = `KIP_REJECT_CYCLES,
	parameter bit          USE_FILTER    = `KIP_NOISE_REJECT_OPT,
	parameter kip_nib_t    PULLDOWN_OPT  = `KIP_PULLDOWN_OPT
) (
	input  wire logic       core_clk,
	input  wire logic       resetn,
	input  wire logic [3:0] key_input_pins,
	input  wire logic [7:0] io_addr,
	input  wire logic [3:0] io_wdata,
	input  wire logic       io_rd,
	input  wire logic       io_wr,
	output logic      [3:0] io_rdata,
	output logic      [3:0] key_pulldown_en,
	output logic            key_irq_req
);

	// ****************************************
	// pull-down straps
	// ****************************************
	// the option is fixed at build time; a flop keeps the output registered
	kip_nib_t pulldown_q;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pulldown_q <= PULLDOWN_OPT;
		end else begin
			pulldown_q <= PULLDOWN_OPT;
		end
	end

	assign key_pulldown_en = pulldown_q;

	// ****************************************
	// pin synchroniser
	// ****************************************
	// pins are asynchronous; only the second stage is read by logic
	kip_nib_t sync1_q;
	kip_nib_t sync2_q;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			sync1_q <= 4'h0;
			sync2_q <= 4'h0;
		end else begin
			sync1_q <= key_input_pins;
			sync2_q <= sync1_q;
		end
	end

	// ****************************************
	// noise rejection
	// ****************************************
	kip_filt_if filt ();

	assign filt.raw = sync2_q;

	kip_filter #(
		.USE_FILTER    (USE_FILTER),
		.REJECT_CYCLES (REJECT_CYCLES)
	) u_filter (
		.core_clk (core_clk),
		.resetn   (resetn),
		.f        (filt)
	);

	// ****************************************
	// address decode
	// ****************************************
	kip_sel_t sel;

	always_comb begin
		case (io_addr)
			`KIP_ADDR_PIN_LEVELS:  sel = KIP_SEL_PINS;
			`KIP_ADDR_IRQ_ENABLES: sel = KIP_SEL_EN;
			`KIP_ADDR_IRQ_FLAG:    sel = KIP_SEL_FLAG;
			default:               sel = KIP_SEL_NONE;
		endcase
	end

	logic en_wr;
	logic flag_rd;

	// writes to the pin word and the flag word fall through unused
	assign en_wr   = io_wr && (sel == KIP_SEL_EN);
	assign flag_rd = io_rd && (sel == KIP_SEL_FLAG);

	// ****************************************
	// interrupt enables
	// ****************************************
	kip_nib_t en_q;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			en_q <= `KIP_RST_IRQ_ENABLES;
		end else if (en_wr) begin
			en_q <= io_wdata;
		end
	end

	// ****************************************
	// edge detection
	// ****************************************
	// the edge is taken on pin-and-enable, so enabling a bit that is
	// already high counts as a new edge; software must avoid that
	kip_nib_t cond;
	kip_nib_t cond_prev_q;
	logic     edge_hit;

	assign cond     = filt.clean & en_q;
	assign edge_hit = |(cond & ~cond_prev_q);

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cond_prev_q <= 4'h0;
		end else begin
			cond_prev_q <= cond;
		end
	end

	// ****************************************
	// interrupt flag
	// ****************************************
	// a set in the reading cycle survives; that read returns flag_q from before the set,
	// so the next read sees the new event
	logic flag_q;
	logic flag_d;

	always_comb begin
		flag_d = flag_q;
		if (flag_rd) begin
			flag_d = 1'b0;
		end
		if (edge_hit) begin
			flag_d = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			flag_q <= `KIP_RST_IRQ_FLAG;
		end else begin
			flag_q <= flag_d;
		end
	end

	// ****************************************
	// interrupt request
	// ****************************************
	logic irq_q;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= flag_d;
		end
	end

	assign key_irq_req = irq_q;

	// ****************************************
	// read data
	// ****************************************
	kip_nib_t rdata_q;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rdata_q <= `KIP_RDATA_IDLE;
		end else if (io_rd) begin
			case (sel)
				KIP_SEL_PINS: rdata_q <= sync2_q;
				KIP_SEL_EN:   rdata_q <= en_q;
				KIP_SEL_FLAG: rdata_q <= {3'h0, flag_q};
				default:      rdata_q <= `KIP_RDATA_IDLE;
			endcase
		end
	end

	assign io_rdata = rdata_q;

	// ****************************************
	// checks
	// ****************************************
	property p_pins_read;
		@(posedge core_clk) disable iff (!resetn)
		io_rd && io_addr == `KIP_ADDR_PIN_LEVELS |=> io_rdata == $past(sync2_q);
	endproperty
	a_pins_read: assert property (p_pins_read) else $error("pin word read mismatch");

	property p_en_write;
		@(posedge core_clk) disable iff (!resetn)
		io_wr && io_addr == `KIP_ADDR_IRQ_ENABLES |=> en_q == $past(io_wdata);
	endproperty
	a_en_write: assert property (p_en_write) else $error("enable write lost");

	property p_en_hold;
		@(posedge core_clk) disable iff (!resetn)
		!(io_wr && io_addr == `KIP_ADDR_IRQ_ENABLES) |=> $stable(en_q);
	endproperty
	a_en_hold: assert property (p_en_hold) else $error("enables changed without write");

	property p_flag_word;
		@(posedge core_clk) disable iff (!resetn)
		flag_rd |=> io_rdata[3:1] == 3'h0 && io_rdata[0] == $past(flag_q);
	endproperty
	a_flag_word: assert property (p_flag_word) else $error("flag word wrong");

	property p_flag_clear;
		@(posedge core_clk) disable iff (!resetn)
		flag_rd && !edge_hit |=> !flag_q;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared by read");

	property p_flag_set;
		@(posedge core_clk) disable iff (!resetn)
		$rose(filt.clean[0]) && en_q[0] && $stable(en_q) |=> flag_q;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("edge did not set flag");

	property p_level_quiet;
		@(posedge core_clk) disable iff (!resetn)
		!flag_q && $stable(filt.clean) && $stable(en_q) |=> !flag_q;
	endproperty
	a_level_quiet: assert property (p_level_quiet) else $error("flag set by level");

	property p_reenable;
		@(posedge core_clk) disable iff (!resetn)
		$rose(en_q[1]) && filt.clean[1] |=> flag_q;
	endproperty
	a_reenable: assert property (p_reenable) else $error("re-enable did not set flag");

	property p_masked;
		@(posedge core_clk) disable iff (!resetn)
		en_q == 4'h0 && !flag_q && !(io_wr && io_addr == `KIP_ADDR_IRQ_ENABLES) |=> !flag_q;
	endproperty
	a_masked: assert property (p_masked) else $error("masked bit set flag");

	property p_irq_follow;
		@(posedge core_clk) disable iff (!resetn)
		key_irq_req == flag_q;
	endproperty
	a_irq_follow: assert property (p_irq_follow) else $error("request differs from flag");

	property p_filter_hold;
		@(posedge core_clk) disable iff (!resetn)
		USE_FILTER && REJECT_CYCLES >= 2 && $rose(filt.clean[2]) |->
			$past(filt.raw[2]) && $past(filt.raw[2], 2);
	endproperty
	a_filter_hold: assert property (p_filter_hold) else $error("filter passed a glitch");

	property p_pulldown;
		@(posedge core_clk) disable iff (!resetn)
		##1 key_pulldown_en == PULLDOWN_OPT;
	endproperty
	a_pulldown: assert property (p_pulldown) else $error("pull-down option lost");

	property p_flag_stand;
		@(posedge core_clk) disable iff (!resetn)
		flag_q && !flag_rd |=> flag_q;
	endproperty
	a_flag_stand: assert property (p_flag_stand) else $error("flag dropped without read");

	property p_set_wins;
		@(posedge core_clk) disable iff (!resetn)
		flag_rd && edge_hit |=> flag_q;
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("edge lost under read clear");

	property p_en_read;
		@(posedge core_clk) disable iff (!resetn)
		io_rd && io_addr == `KIP_ADDR_IRQ_ENABLES |=> io_rdata == $past(en_q);
	endproperty
	a_en_read: assert property (p_en_read) else $error("enable word read mismatch");

	property p_rdata_hold;
		@(posedge core_clk) disable iff (!resetn)
		!io_rd |=> $stable(io_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");

	property p_flag_wr_ignored;
		@(posedge core_clk) disable iff (!resetn)
		io_wr && io_addr == `KIP_ADDR_IRQ_FLAG && !io_rd && !edge_hit |=> flag_q == $past(flag_q);
	endproperty
	a_flag_wr_ignored: assert property (p_flag_wr_ignored) else $error("flag took a write");

	property p_any_edge;
		@(posedge core_clk) disable iff (!resetn)
		|(filt.clean & ~$past(filt.clean) & en_q) && $stable(en_q) |=> flag_q;
	endproperty
	a_any_edge: assert property (p_any_edge) else $error("enabled rise missed");

	property p_fall_quiet;
		@(posedge core_clk) disable iff (!resetn)
		!flag_q && $stable(en_q) && (filt.clean & ~$past(filt.clean)) == 4'h0 |=> !flag_q;
	endproperty
	a_fall_quiet: assert property (p_fall_quiet) else $error("flag set without rise");

endmodule

// file: kip_keys.sv
module kip_keys (
	input  wire logic       core_clk,
	input  wire logic [3:0] pressed,
	input  wire logic [3:0] key_pulldown_en,
	output logic      [3:0] key_input_pins
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] float_q = 4'h0;
	// an open key with no pull-down floats: flip it every cycle so nothing reads it as steady
	always @(posedge core_clk) begin
		float_q <= ~float_q;
	end
	assign key_input_pins = pressed | (~key_pulldown_en & float_q);
endmodule

// file: kip_top_tb.sv
module kip_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int RC = 4;
	logic       core_clk = 1'b0;
	logic       resetn   = 1'b0;
	logic [3:0] pressed  = 4'h0;
	logic [3:0] io_wdata = 4'h0;
	logic [7:0] io_addr  = 8'h00;
	logic       io_rd    = 1'b0;
	logic       io_wr    = 1'b0;
	logic [3:0] io_rdata;
	logic [3:0] key_pulldown_en;
	logic [3:0] key_input_pins;
	logic       key_irq_req;
	int         n_errors   = 0;
	int         n_compared = 0;
	int         cyc        = 0;

	always #10 core_clk = ~core_clk;

	kip_keys keys_u (.core_clk(core_clk), .pressed(pressed), .key_pulldown_en(key_pulldown_en),
		.key_input_pins(key_input_pins));

	kip_top #(.REJECT_CYCLES(RC), .USE_FILTER(1'b1), .PULLDOWN_OPT(4'hF)) dut_u (
		.core_clk(core_clk), .resetn(resetn), .key_input_pins(key_input_pins),
		.io_addr(io_addr), .io_wdata(io_wdata), .io_rd(io_rd), .io_wr(io_wr),
		.io_rdata(io_rdata), .key_pulldown_en(key_pulldown_en), .key_irq_req(key_irq_req));

	// ****************************************
	// access tasks
	// ****************************************
	task automatic step(int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic chk(string what, logic [3:0] exp, logic [3:0] got);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(logic [7:0] a, logic [3:0] v);
		@(posedge core_clk);
		#1;
		io_addr = a;
		io_wdata = v;
		io_wr = 1'b1;
		step(1);
		io_wr = 1'b0;
	endtask

	task automatic rdchk(string what, logic [7:0] a, logic [3:0] exp);
		@(posedge core_clk);
		#1;
		io_addr = a;
		io_rd = 1'b1;
		step(1);
		io_rd = 1'b0;
		chk(what, exp, io_rdata);
	endtask

	// bounded poll: flag is never read here, a read would clear it
	task automatic wait_irq;
		int i;
		for (i = 0; i < 16 && key_irq_req !== 1'b1; i++) step(1);
		chk("irq", 4'h1, {3'h0, key_irq_req});
	endtask

	task report_and_stop;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			report_and_stop();
		end
	end

	// ****************************************
	// tests
	// ****************************************
	initial begin
		step(10);
		resetn = 1'b1;
		chk("pulldown", 4'hF, key_pulldown_en);
		chk("irq", 4'h0, {3'h0, key_irq_req});
		rdchk("enables", 8'hE8, 4'h0);
		rdchk("flag", 8'hED, 4'h0);
		rdchk("unmapped", 8'hE1, 4'h0);
		wr(8'hE8, 4'hA);
		rdchk("enables", 8'hE8, 4'hA);
		pressed = 4'h9;
		wr(8'hE0, 4'h6);
		rdchk("pins", 8'hE0, 4'h9);
		wait_irq();
		wr(8'hED, 4'h0);
		rdchk("flag", 8'hED, 4'h1);
		rdchk("flag", 8'hED, 4'h0);
		chk("irq", 4'h0, {3'h0, key_irq_req});
		pressed = 4'h0;
		step(12);
		$display("test registers done");
		for (int b = 0; b < 4; b++) begin
			wr(8'hE8, 4'h1 << b);
			pressed = ~(4'h1 << b);
			step(12);
			chk("irq masked", 4'h0, {3'h0, key_irq_req});
			pressed = 4'hF;
			step(5);
			chk("irq early", 4'h0, {3'h0, key_irq_req});
			wait_irq();
			rdchk("flag", 8'hED, 4'h1);
			step(12);
			chk("irq level", 4'h0, {3'h0, key_irq_req});
			pressed = 4'h0;
			step(12);
			chk("irq fall", 4'h0, {3'h0, key_irq_req});
		end
		$display("test edges done");
		wr(8'hE8, 4'h1);
		pressed = 4'h1;
		step(2);
		pressed = 4'h0;
		step(12);
		chk("irq glitch", 4'h0, {3'h0, key_irq_req});
		$display("test noise done");
		wr(8'hE8, 4'h0);
		pressed = 4'h2;
		step(12);
		chk("irq masked", 4'h0, {3'h0, key_irq_req});
		wr(8'hE8, 4'h2);
		wait_irq();
		rdchk("flag", 8'hED, 4'h1);
		pressed = 4'h0;
		$display("test enable while high done");
		report_and_stop();
	end
endmodule
